// ### hdl/hfl_pkg.sv
// Shared constants and carriers for the HDLC FIFO level and test status registers
package hfl_pkg;
  localparam int          NUM_CH          = 2;
  localparam logic [7:0]  PAGE_HDLC0      = 8'h0B;
  localparam logic [7:0]  PAGE_HDLC1      = 8'h0C;
  localparam logic [4:0]  ADDR_TEST_STAT  = 5'h1C;
  localparam logic [4:0]  ADDR_LEVEL_SEL  = 5'h1D;
  localparam logic [4:0]  ADDR_IRQ_THR    = 5'h1E;
  localparam int          RX_CLK_BIT      = 3;
  localparam int          TX_CLK_BIT      = 2;
  localparam int          CRC_OK_BIT      = 1;
  localparam int          ADDR_OK_BIT     = 0;
  localparam int          RX_SEL_LSB      = 4;
  localparam int          TX_SEL_LSB      = 0;
  localparam logic [7:0]  SEL_WRITE_MASK  = 8'h77;
  localparam logic [7:0]  LEVEL_SEL_RESET = 8'h00;
  localparam logic [7:0]  IRQ_THR_RESET   = 8'h00;
  localparam logic [7:0]  RX_IRQ_BASE     = 8'h40;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  typedef struct packed {
    logic       rx_enable;
    logic       tx_enable;
    logic       rx_bit_clk;
    logic       tx_bit_clk;
    logic       crc_match;
    logic       addr_match;
    logic [7:0] rx_fifo_count;
    logic [7:0] tx_fifo_count;
  } hfl_ch_in_s;

  typedef struct packed {
    logic rx_full_status;
    logic tx_full_status;
    logic rx_fifo_full_flag;
    logic tx_fifo_low_flag;
  } hfl_ch_out_s;

  // Code k selects 16*(k+1) bytes
  function automatic logic [7:0] hfl_full_level(input logic [2:0] code);
    logic [3:0] steps;
    steps = {1'b0, code} + 4'h1;
    return {steps, 4'h0};
  endfunction : hfl_full_level

  // Code k selects 64+8*k bytes
  function automatic logic [7:0] hfl_rx_irq_level(input logic [2:0] code);
    return RX_IRQ_BASE + {2'b00, code, 3'b000};
  endfunction : hfl_rx_irq_level

  // Code k selects 8*(k+1) bytes
  function automatic logic [7:0] hfl_tx_irq_level(input logic [2:0] code);
    logic [3:0] steps;
    steps = {1'b0, code} + 4'h1;
    return {1'b0, steps, 3'b000};
  endfunction : hfl_tx_irq_level
endpackage : hfl_pkg

// ### hdl/hfl_hdlc_status_regs.sv
// HDLC test status, FIFO level select and FIFO threshold registers for two controllers
`timescale 1ns/10ps
`default_nettype none
module hfl_hdlc_status_regs (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic [7:0]                  CPU_PAGE_I,
  input  wire logic [4:0]                  CPU_ADDR_I,
  input  wire logic                        CPU_WR_I,
  input  wire logic                        CPU_RD_I,
  input  wire logic [7:0]                  CPU_WDATA_I,
  output var  logic [7:0]                  CPU_RDATA_O,
  input  wire hfl_pkg::hfl_ch_in_s  [1:0]  CH_IN_I,
  output var  hfl_pkg::hfl_ch_out_s [1:0]  CH_OUT_O
);
  import hfl_pkg::*;

  typedef struct packed {
    logic [7:0] test_status;
    logic [7:0] level_sel;
    logic [7:0] irq_thr;
    hfl_ch_out_s flags;
  } hfl_ch_state_s;

  typedef struct packed {
    hfl_ch_state_s [NUM_CH-1:0] ch;
    logic [7:0]                 rdata;
  } hfl_state_s;

  hfl_state_s st;
  hfl_state_s next_st;
  logic [NUM_CH-1:0] page_hit;

  assign page_hit[0] = (CPU_PAGE_I == PAGE_HDLC0);
  assign page_hit[1] = (CPU_PAGE_I == PAGE_HDLC1);

  always_comb begin
    logic [7:0] rx_lvl;
    logic [7:0] tx_lvl;
    logic [7:0] rx_thr;
    logic [7:0] tx_thr;
    logic [7:0] rd_mux;
    rx_lvl  = 8'h00;
    tx_lvl  = 8'h00;
    rx_thr  = 8'h00;
    tx_thr  = 8'h00;
    rd_mux  = UNMAPPED_DATA;
    next_st = st;
    for (int i = 0; i < NUM_CH; i++) begin
      // Sampled every cycle so software sees the live engine view
      next_st.ch[i].test_status = 8'h00;
      next_st.ch[i].test_status[RX_CLK_BIT]  = CH_IN_I[i].rx_enable & CH_IN_I[i].rx_bit_clk;
      next_st.ch[i].test_status[TX_CLK_BIT]  = CH_IN_I[i].tx_enable & CH_IN_I[i].tx_bit_clk;
      next_st.ch[i].test_status[CRC_OK_BIT]  = CH_IN_I[i].crc_match;
      next_st.ch[i].test_status[ADDR_OK_BIT] = CH_IN_I[i].addr_match;
      if (CPU_WR_I && page_hit[i]) begin
        if (CPU_ADDR_I == ADDR_LEVEL_SEL) begin
          next_st.ch[i].level_sel = CPU_WDATA_I & SEL_WRITE_MASK;
        end
        if (CPU_ADDR_I == ADDR_IRQ_THR) begin
          next_st.ch[i].irq_thr = CPU_WDATA_I & SEL_WRITE_MASK;
        end
      end
      rx_lvl = hfl_full_level(st.ch[i].level_sel[RX_SEL_LSB +: 3]);
      tx_lvl = hfl_full_level(st.ch[i].level_sel[TX_SEL_LSB +: 3]);
      rx_thr = hfl_rx_irq_level(st.ch[i].irq_thr[RX_SEL_LSB +: 3]);
      tx_thr = hfl_tx_irq_level(st.ch[i].irq_thr[TX_SEL_LSB +: 3]);
      next_st.ch[i].flags.rx_full_status    = CH_IN_I[i].rx_fifo_count >= rx_lvl;
      next_st.ch[i].flags.tx_full_status    = CH_IN_I[i].tx_fifo_count >= tx_lvl;
      next_st.ch[i].flags.rx_fifo_full_flag = CH_IN_I[i].rx_fifo_count >= rx_thr;
      next_st.ch[i].flags.tx_fifo_low_flag  = CH_IN_I[i].tx_fifo_count <= tx_thr;
      if (page_hit[i]) begin
        case (CPU_ADDR_I)
          ADDR_TEST_STAT: rd_mux = st.ch[i].test_status;
          ADDR_LEVEL_SEL: rd_mux = st.ch[i].level_sel;
          ADDR_IRQ_THR:   rd_mux = st.ch[i].irq_thr;
          default:        rd_mux = UNMAPPED_DATA;
        endcase
      end
    end
    // Read data held between strobes so a slow processor sees a stable byte
    if (CPU_RD_I) begin
      next_st.rdata = rd_mux;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NUM_CH; i++) begin
        st.ch[i].test_status <= 8'h00;
        st.ch[i].level_sel   <= LEVEL_SEL_RESET;
        st.ch[i].irq_thr     <= IRQ_THR_RESET;
        st.ch[i].flags       <= '0;
      end
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign CPU_RDATA_O = st.rdata;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      CH_OUT_O[i] = st.ch[i].flags;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  rx_clk_view_a: assert property (
    $past(RST_N_I) |-> st.ch[0].test_status[RX_CLK_BIT] == $past(CH_IN_I[0].rx_enable & CH_IN_I[0].rx_bit_clk))
    else $error("rx bit clock view wrong");
  tx_clk_view_a: assert property (
    !CH_IN_I[1].tx_enable |=> !st.ch[1].test_status[TX_CLK_BIT])
    else $error("tx bit clock view not gated");
  crc_status_a: assert property (
    CH_IN_I[0].crc_match ##1 CH_IN_I[0].crc_match |=> st.ch[0].test_status[CRC_OK_BIT] [*1])
    else $error("crc status not set");
  addr_status_a: assert property (
    !CH_IN_I[1].addr_match |=> !st.ch[1].test_status[ADDR_OK_BIT])
    else $error("address status not clear");
  level_write_a: assert property (
    CPU_WR_I && CPU_PAGE_I == PAGE_HDLC0 && CPU_ADDR_I == ADDR_LEVEL_SEL
    |=> st.ch[0].level_sel == ($past(CPU_WDATA_I) & SEL_WRITE_MASK))
    else $error("level select write lost");
  tx_full_level_a: assert property (
    st.ch[1].level_sel[2:0] == 3'h7 && CH_IN_I[1].tx_fifo_count == 8'h7F
    ##1 st.ch[1].level_sel[2:0] == 3'h7 |-> !st.ch[1].flags.tx_full_status)
    else $error("tx full level off by one");
  thr_write_a: assert property (
    CPU_WR_I && CPU_PAGE_I == PAGE_HDLC1 && CPU_ADDR_I == ADDR_IRQ_THR
    |=> st.ch[1].irq_thr == ($past(CPU_WDATA_I) & SEL_WRITE_MASK))
    else $error("threshold write lost");
  page_isolate_a: assert property (
    CPU_WR_I && CPU_PAGE_I == PAGE_HDLC0 |=> $stable(st.ch[1].level_sel) && $stable(st.ch[1].irq_thr))
    else $error("write leaked to other controller");
  rx_irq_flag_a: assert property (
    st.ch[0].irq_thr[6:4] == 3'h0 && CH_IN_I[0].rx_fifo_count == 8'h40 && $stable(st.ch[0].irq_thr)
    |=> st.ch[0].flags.rx_fifo_full_flag)
    else $error("rx full flag missed at threshold");
  tx_low_flag_a: assert property (
    st.ch[0].irq_thr[2:0] == 3'h7 && CH_IN_I[0].tx_fifo_count == 8'h41 && $stable(st.ch[0].irq_thr)
    |=> !st.ch[0].flags.tx_fifo_low_flag)
    else $error("tx low flag above threshold");
  read_back_a: assert property (
    CPU_RD_I && CPU_PAGE_I == PAGE_HDLC1 && CPU_ADDR_I == ADDR_IRQ_THR |=> CPU_RDATA_O == $past(st.ch[1].irq_thr))
    else $error("read back mismatch");

  // Set checks name the reset input: at the release edge the state is still clear
  // and the disable condition may already read low there
  rx_clk_gate_a: assert property (
    !CH_IN_I[1].rx_enable |=> !st.ch[1].test_status[RX_CLK_BIT])
    else $error("rx bit clock view not gated");
  tx_clk_set_a: assert property (
    RST_N_I && CH_IN_I[0].tx_enable && CH_IN_I[0].tx_bit_clk |=> st.ch[0].test_status[TX_CLK_BIT])
    else $error("tx bit clock view not set");
  tx_clk_copy_a: assert property (
    RST_N_I && CH_IN_I[1].tx_enable && CH_IN_I[1].tx_bit_clk |=> st.ch[1].test_status[TX_CLK_BIT])
    else $error("second tx bit clock view not set");
  crc_clear_a: assert property (
    !CH_IN_I[0].crc_match |=> !st.ch[0].test_status[CRC_OK_BIT])
    else $error("crc status not clear");
  addr_set_a: assert property (
    RST_N_I && CH_IN_I[0].addr_match |=> st.ch[0].test_status[ADDR_OK_BIT])
    else $error("address status not set");
  addr_copy_a: assert property (
    RST_N_I && CH_IN_I[1].addr_match |=> st.ch[1].test_status[ADDR_OK_BIT])
    else $error("second address status not set");
  level1_write_a: assert property (
    CPU_WR_I && CPU_PAGE_I == PAGE_HDLC1 && CPU_ADDR_I == ADDR_LEVEL_SEL
    |=> st.ch[1].level_sel == ($past(CPU_WDATA_I) & SEL_WRITE_MASK))
    else $error("second level select write lost");
  rx_full_low_a: assert property (
    RST_N_I && st.ch[1].level_sel[6:4] == 3'h0 && CH_IN_I[1].rx_fifo_count == 8'h10
    |=> st.ch[1].flags.rx_full_status)
    else $error("rx full status missed at lowest level");
  rx_full_top_a: assert property (
    RST_N_I && st.ch[1].level_sel[6:4] == 3'h7 && CH_IN_I[1].rx_fifo_count == 8'h80
    |=> st.ch[1].flags.rx_full_status)
    else $error("rx full status missed at top level");
  tx_full_low_a: assert property (
    RST_N_I && st.ch[1].level_sel[2:0] == 3'h0 && CH_IN_I[1].tx_fifo_count == 8'h7F
    |=> st.ch[1].flags.tx_full_status)
    else $error("tx full status missed above lowest level");
  rx_irq_below_a: assert property (
    RST_N_I && st.ch[0].irq_thr[6:4] == 3'h7 && CH_IN_I[0].rx_fifo_count == 8'h77
    |=> !st.ch[0].flags.rx_fifo_full_flag)
    else $error("rx full flag below top threshold");
  rx_irq_top_a: assert property (
    RST_N_I && st.ch[0].irq_thr[6:4] == 3'h7 && CH_IN_I[0].rx_fifo_count == 8'h78
    |=> st.ch[0].flags.rx_fifo_full_flag)
    else $error("rx full flag missed at top threshold");
  tx_low_top_a: assert property (
    RST_N_I && st.ch[0].irq_thr[2:0] == 3'h7 && CH_IN_I[0].tx_fifo_count == 8'h40
    |=> st.ch[0].flags.tx_fifo_low_flag)
    else $error("tx low flag missed at top threshold");
  page1_isolate_a: assert property (
    CPU_WR_I && CPU_PAGE_I == PAGE_HDLC1 |=> $stable(st.ch[0].level_sel) && $stable(st.ch[0].irq_thr))
    else $error("write leaked to first controller");
  unmapped_read_a: assert property (
    CPU_RD_I && CPU_PAGE_I != PAGE_HDLC0 && CPU_PAGE_I != PAGE_HDLC1 |=> CPU_RDATA_O == UNMAPPED_DATA)
    else $error("unmapped page read not zero");
  read_level0_a: assert property (
    CPU_RD_I && CPU_PAGE_I == PAGE_HDLC0 && CPU_ADDR_I == ADDR_LEVEL_SEL |=> CPU_RDATA_O == $past(st.ch[0].level_sel))
    else $error("first level select read mismatch");
  read_status1_a: assert property (
    CPU_RD_I && CPU_PAGE_I == PAGE_HDLC1 && CPU_ADDR_I == ADDR_TEST_STAT |=> CPU_RDATA_O == $past(st.ch[1].test_status))
    else $error("second status read mismatch");

  rx_full_seen_c: cover property (st.ch[0].flags.rx_fifo_full_flag ##1 !st.ch[0].flags.rx_fifo_full_flag);
  tx_low_seen_c:  cover property (st.ch[1].flags.tx_fifo_low_flag);
  crc_ok_seen_c:  cover property (st.ch[0].test_status[CRC_OK_BIT]);
  page1_read_c:   cover property (CPU_RD_I && CPU_PAGE_I == PAGE_HDLC1);
  tx_full_seen_c: cover property (st.ch[1].flags.tx_full_status);
endmodule : hfl_hdlc_status_regs
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the HDLC status and FIFO level registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hfl_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              wr;
  logic              rd;
  logic [7:0]        page;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic [7:0]        d;
  logic [4:0]        addr;
  hfl_ch_in_s  [1:0] ch_in;
  hfl_ch_out_s [1:0] ch_out;
  int                n_fail = 0;
  int                checked = 0;

  hfl_hdlc_status_regs dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CPU_PAGE_I(page), .CPU_ADDR_I(addr),
    .CPU_WR_I(wr), .CPU_RD_I(rd), .CPU_WDATA_I(wdata), .CPU_RDATA_O(rdata), .CH_IN_I(ch_in), .CH_OUT_O(ch_out));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] pg, input logic [4:0] ad, input logic [7:0] dt);
    @(posedge clk);
    page  <= pg;
    addr  <= ad;
    wdata <= dt;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Holds read data only until the next read edge, so sample well after
  task automatic rd_reg(input logic [7:0] pg, input logic [4:0] ad, output logic [7:0] dt);
    @(posedge clk);
    page <= pg;
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    repeat (2) @(posedge clk);
    #1 dt = rdata;
  endtask : rd_reg

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_status();
    @(posedge clk);
    ch_in[0] <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00};
    ch_in[1] <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00};
    wr_reg(PAGE_HDLC0, ADDR_TEST_STAT, 8'hFF);
    rd_reg(PAGE_HDLC0, ADDR_TEST_STAT, d);
    check("status0", d, 8'h0A);
    rd_reg(PAGE_HDLC1, ADDR_TEST_STAT, d);
    check("status1", d, 8'h05);
    @(posedge clk);
    ch_in[0] <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00};
    rd_reg(PAGE_HDLC0, ADDR_TEST_STAT, d);
    check("status0b", d, 8'h05);
  endtask : t_status

  task automatic t_level();
    for (int k = 0; k < 8; k++) begin
      wr_reg(PAGE_HDLC1, ADDR_LEVEL_SEL, {1'b0, k[2:0], 1'b0, k[2:0]});
      @(posedge clk);
      ch_in[1].rx_fifo_count <= 8'(16 * (k + 1));
      ch_in[1].tx_fifo_count <= 8'(16 * (k + 1) - 1);
      settle();
      check("rx_full_status", {7'h00, ch_out[1].rx_full_status}, 8'h01);
      check("tx_full_status", {7'h00, ch_out[1].tx_full_status}, 8'h00);
    end
  endtask : t_level

  task automatic t_irq();
    for (int k = 0; k < 8; k++) begin
      wr_reg(PAGE_HDLC0, ADDR_IRQ_THR, {1'b0, k[2:0], 1'b0, k[2:0]});
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        ch_in[0].rx_fifo_count <= 8'(63 + 8 * k + j);
        ch_in[0].tx_fifo_count <= 8'(8 * k + 8 + j);
        settle();
        check("rx_fifo_full_flag", {7'h00, ch_out[0].rx_fifo_full_flag}, 8'(j));
        check("tx_fifo_low_flag", {7'h00, ch_out[0].tx_fifo_low_flag}, 8'(1 - j));
      end
    end
  endtask : t_irq

  // Per-page copies, write mask and an unmapped page
  task automatic t_pages();
    rd_reg(PAGE_HDLC0, ADDR_LEVEL_SEL, d);
    check("level0_reset", d, LEVEL_SEL_RESET);
    wr_reg(PAGE_HDLC1, ADDR_IRQ_THR, 8'hFF);
    wr_reg(PAGE_HDLC0, ADDR_LEVEL_SEL, 8'h21);
    wr_reg(8'h0D, ADDR_LEVEL_SEL, 8'h55);
    rd_reg(PAGE_HDLC1, ADDR_IRQ_THR, d);
    check("irq1", d, 8'h77);
    rd_reg(PAGE_HDLC0, ADDR_LEVEL_SEL, d);
    check("level0", d, 8'h21);
    rd_reg(8'h0D, ADDR_LEVEL_SEL, d);
    check("unmapped", d, UNMAPPED_DATA);
  endtask : t_pages

  // Mid-run reset clears flags and both select registers
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    settle();
    check("flags1_in_reset", {4'h0, ch_out[1]}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(PAGE_HDLC1, ADDR_LEVEL_SEL, d);
    check("level1_after_reset", d, LEVEL_SEL_RESET);
    rd_reg(PAGE_HDLC1, ADDR_IRQ_THR, d);
    check("irq1_after_reset", d, IRQ_THR_RESET);
    check("tx_full_lowest", {7'h00, ch_out[1].tx_full_status}, 8'h01);
  endtask : t_reset

  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    page  = 8'h00;
    addr  = 5'h00;
    wdata = 8'h00;
    ch_in = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_pages();
    t_status();
    t_level();
    t_reset();
    t_irq();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
